// ---- rtl/ubfbg_divider.sv ----
// Purpose: 8-bit half-bit divider counter
// Assumes: tick is one base-clock pulse
// Notes: half pulses every k ticks, so a bit is 2k ticks
`timescale 1ns/10ps
`default_nettype none
module ubfbg_divider (
    // clock and control
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic run,
    input wire logic clear,
    input wire logic tick,
    input wire logic [7:0] k,
    // half-bit pulse
    output logic half
);
    logic [7:0] cnt;
    // count ticks, wrap at k; a stopped counter sits at zero, but only while enabled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= 8'h00;
            half <= 1'b0;
        end else if (ce) begin
            half <= 1'b0;
            if (!run) begin
                cnt <= 8'h00;
            end else if (clear) begin
                cnt <= 8'h00;
            end else if (tick) begin
                if (cnt + 8'h01 >= k) begin
                    cnt <= 8'h00;
                    half <= 1'b1;
                end else begin
                    cnt <= cnt + 8'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/ubfbg_pkg.sv ----
// Purpose: constants for the break-field uart with baud generator
// Assumes: axi4-lite register access, 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
package ubfbg_pkg;
    localparam logic [7:0] UBFBG_OFS_MODE = 8'h00;
    localparam logic [7:0] UBFBG_OFS_LINE = 8'h04;
    localparam logic [7:0] UBFBG_OFS_CKSEL = 8'h08;
    localparam logic [7:0] UBFBG_OFS_DIV = 8'h0c;
    localparam logic [7:0] UBFBG_OFS_TXH = 8'h10;
    localparam logic [7:0] UBFBG_OFS_RXH = 8'h14;
    localparam logic [7:0] UBFBG_OFS_ERR = 8'h18;
    localparam logic [7:0] UBFBG_OFS_STAT = 8'h1c;
    localparam int UBFBG_B_POWER = 7;
    localparam int UBFBG_B_TXE = 6;
    localparam int UBFBG_B_RXE = 5;
    localparam int UBFBG_B_RXFLAG = 7;
    localparam int UBFBG_B_RXTRIG = 6;
    localparam int UBFBG_B_TXTRIG = 5;
    localparam int UBFBG_B_LEN_HI = 4;
    localparam int UBFBG_B_LEN_LO = 2;
    localparam logic [7:0] UBFBG_RST_RXH = 8'hff;
    localparam logic [7:0] UBFBG_RST_DIV = 8'hff;
    localparam logic [4:0] UBFBG_BREAK_BASE = 5'h0d;
    localparam logic [4:0] UBFBG_BREAK_MIN_RX = 5'h0b;
    localparam logic [3:0] UBFBG_CK_MAXDIV = 4'ha;
    localparam logic [3:0] UBFBG_CK_TIMER = 4'hb;
    localparam logic [1:0] UBFBG_RESP_OK = 2'h0;
    localparam logic [1:0] UBFBG_RESP_SLVERR = 2'h2;
endpackage

// ---- rtl/ubfbg_top.sv ----
// Purpose: uart break-field transmit/receive with dedicated baud generator
// Assumes: single clock aclk, synchronous active-low reset, axi4-lite slave
// Notes: bit frame is 8n1 with no parity; error flags stay zero in break mode
`timescale 1ns/10ps
`default_nettype none
module ubfbg_top (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // write address
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    // write data
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    // write response
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // read address
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    // read data
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // serial pins and timer source
    input wire logic serial_in,
    input wire logic timer_output_source,
    output logic serial_out,
    // events
    output logic tx_done_irq,
    output logic rx_done_irq
);
    import ubfbg_pkg::*;

    typedef enum logic [3:0] {
        UBFBG_T_IDLE = 4'b0001,
        UBFBG_T_BRK = 4'b0010,
        UBFBG_T_DATA = 4'b0100,
        UBFBG_T_WAIT = 4'b1000
    } ubfbg_tx_e;
    typedef enum logic [2:0] {
        UBFBG_R_IDLE = 3'b001,
        UBFBG_R_START = 3'b010,
        UBFBG_R_DATA = 3'b100
    } ubfbg_rx_e;

    logic [7:0] operation_mode_reg;
    logic [7:0] line_control_reg;
    logic [7:0] clock_select_reg;
    logic [7:0] baud_divisor_reg;
    logic [7:0] tx_holding;
    logic tx_full;
    logic [7:0] rx_holding;
    logic [7:0] rx_shifter;
    logic [7:0] rx_error_status;
    logic [7:0] aw_addr;
    logic aw_have;
    logic [31:0] w_data;
    logic w_have;
    logic [10:0] pre;
    logic tmr_q1, tmr_q2, tmr_q3;
    logic in_q1, in_q2, smp_a, smp_b, rx_level;
    ubfbg_tx_e tx_st;
    ubfbg_rx_e rx_st;
    logic [5:0] tx_halves;
    logic [3:0] tx_bits;
    logic [8:0] tx_shift;
    logic [5:0] rx_halves;
    logic [4:0] rx_width;
    logic [3:0] rx_bits;
    logic rx_low_run;

    // field decode
    wire unit_power_on = operation_mode_reg[UBFBG_B_POWER];
    wire tx_enable_bit = operation_mode_reg[UBFBG_B_TXE];
    wire rx_enable_bit = operation_mode_reg[UBFBG_B_RXE];
    wire break_tx_trigger = line_control_reg[UBFBG_B_TXTRIG];
    wire break_rx_trigger = line_control_reg[UBFBG_B_RXTRIG];
    wire break_rx_flag = line_control_reg[UBFBG_B_RXFLAG];
    wire [2:0] break_length_select = line_control_reg[UBFBG_B_LEN_HI:UBFBG_B_LEN_LO];
    wire [3:0] base_clock_select = clock_select_reg[3:0];
    wire [7:0] divisor_value = baud_divisor_reg;
    wire tx_run = unit_power_on && tx_enable_bit;
    wire rx_run = unit_power_on && rx_enable_bit;
    wire [4:0] break_bits = UBFBG_BREAK_BASE + {2'b00, break_length_select};

    // base clock tick: prescaler carry or timer rising edge, gated by power
    wire [11:0] pre_next = {1'b0, pre} + 12'h001;
    wire [11:0] carry = pre_next ^ {1'b0, pre};
    wire pre_tick = (base_clock_select == 4'h0) ? 1'b1 : carry[base_clock_select];
    wire tmr_tick = tmr_q2 && !tmr_q3;
    wire sel_ok = base_clock_select <= UBFBG_CK_TIMER;
    wire base_tick = unit_power_on && sel_ok && ((base_clock_select == UBFBG_CK_TIMER) ? tmr_tick : pre_tick);

    // bus handshakes
    logic w_strb0;
    logic w_data_strb;
    assign w_data_strb = w_strb0;
    wire do_write = aw_have && w_have && !s_bvalid;
    wire do_read = s_arvalid && s_arready;
    // next channel state, so the readies can come from flip-flops
    wire next_aw_have = (aw_have || (s_awvalid && s_awready)) && !do_write;
    wire next_w_have = (w_have || (s_wvalid && s_wready)) && !do_write;
    wire next_bvalid = do_write || (s_bvalid && !s_bready);
    wire next_rvalid = do_read || (s_rvalid && !s_rready);
    wire w_mode = do_write && aw_addr == UBFBG_OFS_MODE && w_data_strb;
    wire w_line = do_write && aw_addr == UBFBG_OFS_LINE && w_data_strb;
    wire w_cksel = do_write && aw_addr == UBFBG_OFS_CKSEL && w_data_strb;
    wire w_div = do_write && aw_addr == UBFBG_OFS_DIV && w_data_strb;
    wire w_txh = do_write && aw_addr == UBFBG_OFS_TXH && w_data_strb;
    wire w_ok = aw_addr == UBFBG_OFS_MODE || aw_addr == UBFBG_OFS_LINE || aw_addr == UBFBG_OFS_CKSEL
        || aw_addr == UBFBG_OFS_DIV || aw_addr == UBFBG_OFS_TXH;

    // dividers
    logic tx_half, rx_half;
    wire tx_clear = (w_txh || break_tx_trigger) && tx_st == UBFBG_T_IDLE;
    wire tx_frame_next = tx_st == UBFBG_T_DATA && tx_half && tx_halves == 6'h01 && tx_bits == 4'h9 && tx_full;
    wire rx_fall = rx_st == UBFBG_R_IDLE && !rx_level && rx_low_run;
    ubfbg_divider u_txdiv (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .run(tx_run),
        .clear(tx_clear || tx_frame_next),
        .tick(base_tick),
        .k(divisor_value),
        .half(tx_half)
    );
    ubfbg_divider u_rxdiv (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .run(rx_run && rx_st != UBFBG_R_IDLE),
        .clear(1'b0),
        .tick(base_tick),
        .k(divisor_value),
        .half(rx_half)
    );

    // prescaler and synchronisers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre <= 11'h000;
            tmr_q1 <= 1'b0;
            tmr_q2 <= 1'b0;
            tmr_q3 <= 1'b0;
            in_q1 <= 1'b1;
            in_q2 <= 1'b1;
        end else if (ce) begin
            pre <= pre_next[10:0];
            tmr_q1 <= timer_output_source;
            tmr_q2 <= tmr_q1;
            tmr_q3 <= tmr_q2;
            in_q1 <= serial_in;
            in_q2 <= in_q1;
        end
    end

    // noise filter on base clock: level moves when two samples agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            smp_a <= 1'b1;
            smp_b <= 1'b1;
            rx_level <= 1'b1;
        end else if (ce && base_tick) begin
            smp_a <= in_q2;
            smp_b <= smp_a;
            if (smp_a == smp_b) begin
                rx_level <= smp_b;
            end
        end
    end

    // bus channel capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb0 <= 1'b0;
            s_bvalid <= 1'b0;
            s_bresp <= UBFBG_RESP_OK;
            s_awready <= 1'b1;
            s_wready <= 1'b1;
        end else if (ce) begin
            if (s_awvalid && s_awready) begin
                aw_have <= 1'b1;
                aw_addr <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_have <= 1'b1;
                w_data <= s_wdata;
                w_strb0 <= s_wstrb[0];
            end
            if (do_write) begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= w_ok ? UBFBG_RESP_OK : UBFBG_RESP_SLVERR;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
            s_awready <= !next_aw_have && !next_bvalid;
            s_wready <= !next_w_have && !next_bvalid;
        end
    end

    // read path
    wire r_err = s_araddr == UBFBG_OFS_ERR;
    wire r_rxh = s_araddr == UBFBG_OFS_RXH;
    logic [7:0] r_mux;
    always_comb begin
        r_mux = 8'h00;
        if (s_araddr == UBFBG_OFS_MODE) begin
            r_mux = operation_mode_reg;
        end else if (s_araddr == UBFBG_OFS_LINE) begin
            r_mux = line_control_reg;
        end else if (s_araddr == UBFBG_OFS_CKSEL) begin
            r_mux = clock_select_reg;
        end else if (s_araddr == UBFBG_OFS_DIV) begin
            r_mux = baud_divisor_reg;
        end else if (s_araddr == UBFBG_OFS_TXH) begin
            r_mux = tx_holding;
        end else if (r_rxh) begin
            r_mux = rx_holding;
        end else if (r_err) begin
            r_mux = rx_error_status;
        end else if (s_araddr == UBFBG_OFS_STAT) begin
            r_mux = {6'h00, tx_full, tx_st != UBFBG_T_IDLE};
        end
    end
    wire r_ok = s_araddr <= UBFBG_OFS_STAT && s_araddr[1:0] == 2'b00;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_rvalid <= 1'b0;
            s_arready <= 1'b1;
            s_rdata <= 32'h0000_0000;
            s_rresp <= UBFBG_RESP_OK;
        end else if (ce) begin
            if (do_read) begin
                s_rvalid <= 1'b1;
                s_rdata <= {24'h000000, r_mux};
                s_rresp <= r_ok ? UBFBG_RESP_OK : UBFBG_RESP_SLVERR;
            end else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
            end
            s_arready <= !next_rvalid;
        end
    end

    // transmitter: break field and 8n1 frames
    wire tx_bit_end = tx_half && tx_halves == 6'h01;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_st <= UBFBG_T_IDLE;
            tx_halves <= 6'h00;
            tx_bits <= 4'h0;
            tx_shift <= 9'h1ff;
            serial_out <= 1'b1;
            tx_done_irq <= 1'b0;
        end else if (ce) begin
            tx_done_irq <= 1'b0;
            if (!tx_run) begin
                tx_st <= UBFBG_T_IDLE;
                serial_out <= 1'b1;
            end else begin
                case (tx_st)
                    UBFBG_T_IDLE: begin
                        serial_out <= 1'b1;
                        tx_halves <= 6'h02;
                        if (break_tx_trigger) begin
                            tx_st <= UBFBG_T_BRK;
                            tx_bits <= 4'h0;
                            tx_halves <= {break_bits, 1'b0};
                        end else if (tx_full) begin
                            tx_st <= UBFBG_T_DATA;
                            tx_bits <= 4'h0;
                            tx_shift <= {tx_holding, 1'b0};
                        end
                    end
                    UBFBG_T_BRK: begin
                        serial_out <= 1'b0;
                        if (tx_half) begin
                            tx_halves <= tx_halves - 6'h01;
                            if (tx_halves == 6'h01) begin
                                tx_st <= UBFBG_T_IDLE;
                                serial_out <= 1'b1;
                                tx_done_irq <= 1'b1;
                            end
                        end
                    end
                    UBFBG_T_DATA: begin
                        serial_out <= tx_shift[0];
                        if (tx_half) begin
                            tx_halves <= tx_halves - 6'h01;
                            if (tx_bit_end) begin
                                tx_halves <= 6'h02;
                                tx_shift <= {1'b1, tx_shift[8:1]};
                                tx_bits <= tx_bits + 4'h1;
                                if (tx_bits == 4'h9) begin
                                    tx_st <= UBFBG_T_WAIT;
                                    tx_done_irq <= 1'b1;
                                end
                            end
                        end
                    end
                    default: begin
                        tx_st <= UBFBG_T_IDLE;
                    end
                endcase
            end
        end
    end

    // receiver: start check, bit shifting, break width
    wire rx_mid = rx_half && rx_halves == 6'h01;
    wire is_break = break_rx_trigger;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_st <= UBFBG_R_IDLE;
            rx_halves <= 6'h00;
            rx_bits <= 4'h0;
            rx_width <= 5'h00;
            rx_shifter <= 8'hff;
            rx_done_irq <= 1'b0;
            rx_low_run <= 1'b1; // idle line level, no false edge
        end else if (ce) begin
            rx_done_irq <= 1'b0;
            rx_low_run <= rx_level;
            if (!rx_run) begin
                rx_st <= UBFBG_R_IDLE;
            end else begin
                case (rx_st)
                    UBFBG_R_IDLE: begin
                        if (rx_fall) begin
                            rx_st <= UBFBG_R_START;
                            rx_halves <= 6'h01;
                            rx_width <= 5'h00;
                        end
                    end
                    UBFBG_R_START: begin
                        if (rx_half) begin
                            if (rx_level) begin
                                rx_st <= UBFBG_R_IDLE;
                            end else begin
                                rx_st <= UBFBG_R_DATA;
                                rx_halves <= 6'h02;
                                rx_bits <= 4'h0;
                                rx_width <= 5'h01;
                            end
                        end
                    end
                    UBFBG_R_DATA: begin
                        if (rx_half) begin
                            rx_halves <= rx_halves - 6'h01;
                        end
                        if (rx_mid) begin
                            rx_halves <= 6'h02;
                            if (is_break) begin
                                if (rx_level) begin
                                    rx_st <= UBFBG_R_IDLE;
                                    rx_done_irq <= rx_width >= UBFBG_BREAK_MIN_RX;
                                end else if (rx_width != 5'h1f) begin
                                    rx_width <= rx_width + 5'h01;
                                end
                            end else begin
                                rx_bits <= rx_bits + 4'h1;
                                if (rx_bits == 4'h8) begin
                                    rx_st <= UBFBG_R_IDLE;
                                    rx_done_irq <= 1'b1;
                                end else begin
                                    rx_shifter <= {rx_level, rx_shifter[7:1]};
                                end
                            end
                        end
                    end
                    default: begin
                        rx_st <= UBFBG_R_IDLE;
                    end
                endcase
            end
        end
    end
    wire brk_ok = rx_st == UBFBG_R_DATA && rx_mid && is_break && rx_level && rx_width >= UBFBG_BREAK_MIN_RX;
    wire norm_done = rx_st == UBFBG_R_DATA && rx_mid && !is_break && rx_bits == 4'h8;
    wire frm_err = norm_done && !rx_level;
    wire tx_load = tx_st == UBFBG_T_IDLE && tx_run && tx_full && !break_tx_trigger;
    wire brk_tx_end = tx_st == UBFBG_T_BRK && tx_half && tx_halves == 6'h01;

    // register file
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            operation_mode_reg <= 8'h00;
            line_control_reg <= 8'h00;
            clock_select_reg <= 8'h00;
            baud_divisor_reg <= UBFBG_RST_DIV;
            tx_holding <= 8'h00;
            tx_full <= 1'b0;
            rx_holding <= UBFBG_RST_RXH;
            rx_error_status <= 8'h00;
        end else if (ce) begin
            if (w_mode) begin
                operation_mode_reg <= w_data[7:0];
            end
            if (w_cksel) begin
                clock_select_reg <= {4'h0, w_data[3:0]};
            end
            if (w_div) begin
                baud_divisor_reg <= w_data[7:0];
            end
            if (w_line) begin
                line_control_reg[UBFBG_B_LEN_HI:0] <= w_data[UBFBG_B_LEN_HI:0];
                line_control_reg[UBFBG_B_TXTRIG] <= w_data[UBFBG_B_TXTRIG] && tx_run;
                line_control_reg[UBFBG_B_RXTRIG] <= w_data[UBFBG_B_RXTRIG] && rx_run;
                line_control_reg[UBFBG_B_RXFLAG] <= w_data[UBFBG_B_RXTRIG] && rx_run;
            end
            if (brk_tx_end) begin
                line_control_reg[UBFBG_B_TXTRIG] <= 1'b0;
            end
            if (brk_ok) begin
                line_control_reg[UBFBG_B_RXTRIG] <= 1'b0;
                line_control_reg[UBFBG_B_RXFLAG] <= 1'b0;
            end
            if (tx_load) begin
                tx_full <= 1'b0;
            end
            if (w_txh) begin
                tx_holding <= w_data[7:0];
                tx_full <= 1'b1;
            end
            if (do_read && r_err) begin
                rx_error_status <= 8'h00;
            end
            if (norm_done) begin
                rx_error_status[1] <= frm_err;
                if (rx_level) begin
                    rx_holding <= rx_shifter;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- test/ubfbg_assertions.sv ----
// Purpose: port checks for ubfbg_top
// Assumes: one clock, sync low reset
// Notes: bound from the bench top
`timescale 1ns/10ps
`default_nettype none
module ubfbg_assertions (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic s_awvalid, s_awready, s_wvalid, s_wready,
    input wire logic s_bvalid, s_bready, s_arvalid, s_arready,
    input wire logic s_rvalid, s_rready,
    input wire logic [31:0] s_rdata,
    // pins and events
    input wire logic serial_in, serial_out, tx_done_irq, rx_done_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both write channels taken at one edge
    sequence s_wr_taken;
        s_awvalid && s_awready && s_wvalid && s_wready;
    endsequence
    // device output idles high for some cycles
    sequence s_line_idle;
        serial_out [*4];
    endsequence
    AST_WR_ANSWER: assert property (s_wr_taken |-> ##[1:2] s_bvalid)
        else $error("late write answer");
    AST_RD_ANSWER: assert property (s_arvalid && s_arready |=> s_rvalid)
        else $error("late read answer");
    AST_B_STANDS: assert property (s_bvalid && !s_bready |=> s_bvalid)
        else $error("bvalid dropped");
    AST_R_STANDS: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
        else $error("read answer changed");
    AST_WR_REFUSED: assert property (s_bvalid |-> !s_awready && !s_wready)
        else $error("write taken while answering");
    AST_RD_REFUSED: assert property (s_rvalid |-> !s_arready)
        else $error("read taken while answering");
    AST_TXIRQ_PULSE: assert property (tx_done_irq |=> !tx_done_irq)
        else $error("tx event too long");
    AST_RXIRQ_PULSE: assert property (rx_done_irq |=> !rx_done_irq)
        else $error("rx event too long");
    AST_TX_IDLE: assert property (tx_done_irq |=> s_line_idle)
        else $error("output not idle after frame");
    AST_RX_STOP_HIGH: assert property (rx_done_irq |-> $past(serial_in, 2))
        else $error("rx event without high input");
endmodule
`default_nettype wire

// ---- test/ubfbg_partner.sv ----
// Purpose: remote serial node facing ubfbg_top
// Assumes: node always drives its line, idle high
// Notes: measures each low run on the device output
`timescale 1ns/10ps
`default_nettype none
module ubfbg_partner (
    // clock and lines
    input wire logic aclk,
    input wire logic serial_out,
    output logic line
);
    logic [15:0] cnt = 16'h0;
    logic [15:0] low_len = 16'h0;
    initial line = 1'b1;
    // hold the line low for n cycles, then idle high
    task automatic send_low(input int n);
        @(posedge aclk);
        line <= 1'b0;
        repeat (n) @(posedge aclk);
        line <= 1'b1;
    endtask
    // length of the latest low run
    always @(posedge aclk) begin
        if (serial_out === 1'b0) cnt <= cnt + 16'h1;
        else if (cnt != 16'h0) begin
            low_len <= cnt;
            cnt <= 16'h0;
        end
    end
endmodule
`default_nettype wire

// ---- test/ubfbg_top_tb.sv ----
// Purpose: self-checking bench for ubfbg_top
// Assumes: base clock code 0, small random divisor
// Notes: all results pass through one queue
`timescale 1ns/10ps
`default_nettype none
module ubfbg_top_tb;
    import ubfbg_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, tos = 1'b0;
    logic [7:0] s_awaddr = 8'h0, s_araddr = 8'h0;
    logic [31:0] s_wdata = 32'h0, s_rdata;
    logic [3:0] s_wstrb = 4'hf;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, serial_in, serial_out, tx_done_irq, rx_done_irq;
    logic [1:0] s_bresp, s_rresp;
    logic [33:0] exq [$];
    int err_count = 0, n_tests = 0, rx_irqs = 0, k, f;
    always #12.5 aclk = ~aclk;
    ubfbg_top u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
        .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .serial_in(serial_in), .timer_output_source(tos), .serial_out(serial_out), .tx_done_irq(tx_done_irq),
        .rx_done_irq(rx_done_irq));
    ubfbg_partner u_peer (.aclk(aclk), .serial_out(serial_out), .line(serial_in));
    // oldest note against a seen value
    task automatic chk(input logic [33:0] g);
        logic [33:0] e;
        e = exq.pop_front();
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp(input logic [33:0] g, input logic [33:0] e);
        exq.push_back(e);
        chk(g);
    endtask
    // bus write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        exq.push_back({r, 32'h0});
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
            if (s_bvalid) s_bready <= 1'b0;
        end while (s_awvalid || s_wvalid || s_bready);
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge aclk);
        exq.push_back(e);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_arready) s_arvalid <= 1'b0;
            if (s_rvalid) s_rready <= 1'b0;
        end while (s_arvalid || s_rready);
    endtask
    // watch answers and receive events
    always @(posedge aclk) begin
        if (rx_done_irq === 1'b1) rx_irqs++;
        if (s_bvalid === 1'b1 && s_bready === 1'b1) chk({s_bresp, 32'h0});
        if (s_rvalid === 1'b1 && s_rready === 1'b1) chk({s_rresp, s_rdata});
    end
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // main sequence
    initial begin
        void'($urandom(32'hd059));
        k = 4 + $urandom % 3;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(UBFBG_OFS_DIV, {UBFBG_RESP_OK, 24'h0, UBFBG_RST_DIV});
        rd(UBFBG_OFS_RXH, {UBFBG_RESP_OK, 24'h0, UBFBG_RST_RXH});
        rd(8'h20, {UBFBG_RESP_SLVERR, 32'h0});
        wr(8'h24, 32'h1, UBFBG_RESP_SLVERR);
        wr(UBFBG_OFS_CKSEL, 32'h0, UBFBG_RESP_OK);
        wr(UBFBG_OFS_DIV, 32'(k), UBFBG_RESP_OK);
        wr(UBFBG_OFS_MODE, 32'hc0, UBFBG_RESP_OK);
        cmp(34'(serial_out), 34'h1);
        $display("registers done");
        for (f = 0; f < 8; f++) begin
            wr(UBFBG_OFS_LINE, 32'h20 | (32'(f) << 2), UBFBG_RESP_OK);
            for (int i = 0; i < 50 * k && tx_done_irq !== 1'b1; i++) @(posedge aclk);
            cmp(34'(tx_done_irq), 34'h1);
            repeat (6 * k) @(posedge aclk);
            cmp(34'(u_peer.low_len), 34'((13 + f) * 2 * k));
            cmp(34'(serial_out), 34'h1);
            rd(UBFBG_OFS_LINE, {UBFBG_RESP_OK, 24'h0, 8'(f << 2)});
        end
        $display("break transmit done");
        wr(UBFBG_OFS_MODE, 32'he0, UBFBG_RESP_OK);
        wr(UBFBG_OFS_LINE, 32'h40, UBFBG_RESP_OK);
        u_peer.send_low(24 * k);
        repeat (4 * k) @(posedge aclk);
        cmp(34'(rx_irqs), 34'h1);
        rd(UBFBG_OFS_LINE, {UBFBG_RESP_OK, 32'h0});
        rd(UBFBG_OFS_RXH, {UBFBG_RESP_OK, 24'h0, UBFBG_RST_RXH});
        rd(UBFBG_OFS_ERR, {UBFBG_RESP_OK, 32'h0});
        wr(UBFBG_OFS_LINE, 32'h40, UBFBG_RESP_OK);
        u_peer.send_low(18 * k);
        repeat (24 * k) @(posedge aclk);
        cmp(34'(rx_irqs), 34'h1);
        rd(UBFBG_OFS_LINE, {UBFBG_RESP_OK, 24'h0, 8'hc0});
        // short glitch must be rejected, then one frame with bit0 low
        wr(UBFBG_OFS_LINE, 32'h0, UBFBG_RESP_OK);
        u_peer.send_low(2);
        repeat (4 * k) @(posedge aclk);
        u_peer.send_low(4 * k);
        repeat (24 * k) @(posedge aclk);
        cmp(34'(rx_irqs), 34'h2);
        rd(UBFBG_OFS_RXH, {UBFBG_RESP_OK, 24'h0, 8'hfe});
        rd(UBFBG_OFS_ERR, {UBFBG_RESP_OK, 32'h0});
        $display("break receive done");
        end_of_test();
    end
    // watchdog against a hang
    initial begin
        #(25 * 60000);
        err_count++;
        end_of_test();
    end
endmodule
bind ubfbg_top ubfbg_assertions u_chk (.aclk(aclk), .aresetn(aresetn), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid), .s_rready(s_rready), .s_rdata(s_rdata),
    .serial_in(serial_in), .serial_out(serial_out), .tx_done_irq(tx_done_irq), .rx_done_irq(rx_done_irq));
`default_nettype wire
